/* File: design/clock_state_reset_control.sv */
// Clock and state controller: clock enables, dividers, power states, resets, boot straps.
// Clocks are modelled as one-cycle enables on core_clk; the slow oscillator arrives as a
// synchronous tick input. Registers are reached over Avalon-MM.
`timescale 1ns/10ps
module clock_state_reset_control (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic power_on_reset_n,
	input wire logic power_fail_n,
	input wire logic user_reset_n,
	input wire logic slow_osc_tick,
	input wire logic main_pll_locked,
	input wire logic wake_event,
	input wire logic wakeup_pin,
	input wire logic sdram_self_refresh_ack,
	input wire logic boot_media_select,
	input wire logic boot_width_bit0,
	input wire logic boot_width_bit1,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic system_reset_n,
	output logic domain_reset_n,
	output logic sdram_self_refresh_req,
	output logic core_clock_en,
	output logic bus_clock_en,
	output logic periph_clock_en,
	output logic xtal_clock_en,
	output logic usb_pll_en,
	output logic main_osc_en,
	output logic display_en,
	output logic rtc_second_tick,
	output logic pgm_clock_en,
	output logic boot_sync_media,
	output logic [1:0] boot_width,
	output logic boot_flash,
	output logic boot_mode_reg_init,
	output logic boot_bank_sync4
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Where a reset request sends the sequencer from any live state. Soft resets park
	// the SDRAM in self-refresh first so its contents survive. Power-on goes straight
	// to reset, because there is nothing in the SDRAM worth keeping yet.
	function automatic csr_pkg::pstate_t reset_target(input logic por_n);
		reset_target = por_n ? csr_pkg::ST_SREFRESH : csr_pkg::ST_RESET;
	endfunction : reset_target

	// A power-control request bit, honoured only at the edge where the bus answers.
	// Acting on the request edge instead would change state before the master
	// has seen the access complete, which is a hazard if it ever aborts.
	function automatic logic pwrctl_bit(input logic wr, input logic taken,
		input logic [3:0] addr, input logic bit_val);
		pwrctl_bit = wr && taken && addr == csr_pkg::ADDR_PWRCTL && bit_val;
	endfunction : pwrctl_bit

	// Clocks are not gated here: every clock output is an enable that a clock tree
	// outside this block uses. This keeps the block in one timing domain, at
	// the cost of enables that only approximate the real divided clock edges.
	// ------------------------------------------------------------
	// Reset combining
	// ------------------------------------------------------------
	logic por_q;
	logic soft_q;
	logic [1:0] kind_q;
	logic [2:0] srcs_q;
	logic [2:0] sr_cnt_q;
	logic strap_pending_q;
	csr_pkg::pstate_t state_q;
	logic any_rst;
	assign any_rst = !power_on_reset_n || !power_fail_n || !user_reset_n;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			por_q <= 1'b1;
			soft_q <= 1'b0;
		end else begin
			por_q <= !power_on_reset_n;
			soft_q <= !power_fail_n || !user_reset_n;
		end
	end

	// Soft resets leave the SDRAM config and RTC domain alone; only POR clears it.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			domain_reset_n <= 1'b0;
		end else begin
			domain_reset_n <= power_on_reset_n;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			kind_q <= csr_pkg::KIND_POR;
			srcs_q <= 3'h1;
		end else if (any_rst) begin
			srcs_q <= {!user_reset_n, !power_fail_n, !power_on_reset_n};
			if (!power_on_reset_n) begin
				kind_q <= csr_pkg::KIND_POR;
			end else if (!power_fail_n) begin
				kind_q <= csr_pkg::KIND_PWRFAIL;
			end else begin
				kind_q <= csr_pkg::KIND_USER;
			end
		end
	end

	// ------------------------------------------------------------
	// Power state sequencer
	// ------------------------------------------------------------
	// Standby is the home state after any reset. Software may only move to Halt or
	// back to Standby from Run; Halt waits for a wake event and any reset request
	// overrides all other transitions.
	logic halt_req;
	logic run_req;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_q <= csr_pkg::ST_RESET;
			sr_cnt_q <= 3'h0;
		end else begin
			case (state_q)
				csr_pkg::ST_RUN: begin
					if (any_rst) begin
						state_q <= reset_target(power_on_reset_n);
						sr_cnt_q <= 3'h0;
					end else if (halt_req) begin
						state_q <= csr_pkg::ST_HALT;
					end else if (run_req) begin
						state_q <= csr_pkg::ST_STANDBY;
					end
				end
				csr_pkg::ST_HALT: begin
					if (any_rst) begin
						state_q <= reset_target(power_on_reset_n);
						sr_cnt_q <= 3'h0;
					end else if (wake_event) begin
						state_q <= csr_pkg::ST_RUN;
					end
				end
				csr_pkg::ST_STANDBY: begin
					// Leaving Standby needs the main PLL locked, or the core would run
					// from an unsettled clock.
					if (any_rst) begin
						state_q <= reset_target(power_on_reset_n);
						sr_cnt_q <= 3'h0;
					end else if (wakeup_pin && main_pll_locked) begin
						state_q <= csr_pkg::ST_RUN;
					end
				end
				csr_pkg::ST_SREFRESH: begin
					// Wait for the SDRAM controller, bounded so a dead controller cannot hang reset.
					sr_cnt_q <= sr_cnt_q + 3'h1;
					if (!power_on_reset_n || sdram_self_refresh_ack
						|| sr_cnt_q == csr_pkg::SREFRESH_CYCLES) begin
						state_q <= csr_pkg::ST_RESET;
					end
				end
				csr_pkg::ST_RESET: begin
					if (!any_rst) begin
						state_q <= csr_pkg::ST_STANDBY;
					end
				end
				default: begin
					state_q <= csr_pkg::ST_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			system_reset_n <= 1'b0;
			sdram_self_refresh_req <= 1'b0;
		end else begin
			system_reset_n <= !any_rst && state_q != csr_pkg::ST_RESET
				&& state_q != csr_pkg::ST_SREFRESH;
			sdram_self_refresh_req <= state_q == csr_pkg::ST_SREFRESH;
		end
	end

	// ------------------------------------------------------------
	// Clock dividers and gating
	// ------------------------------------------------------------
	logic [7:0] clkset_q;
	logic [7:0] pgmdiv_q;
	logic [1:0] hdiv_cnt_q;
	logic [2:0] pdiv_cnt_q;
	logic [7:0] pgm_cnt_q;
	// The bus and peripheral divider counters run in every state so that ratios stay in phase when
	// the enables come back; the programmable divider counter holds outside Run and Halt.
	// A ratio change takes effect on the next cycle, even mid-period, as each counter compares against the live setting.
	logic bus_gate_q;
	logic running;
	logic bus_tick;
	logic [2:0] pdiv_max;
	assign running = state_q == csr_pkg::ST_RUN || state_q == csr_pkg::ST_HALT;
	assign bus_tick = hdiv_cnt_q == clkset_q[1:0];
	always_comb begin
		case (clkset_q[3:2])
			2'h0: pdiv_max = 3'h1;
			2'h1: pdiv_max = 3'h3;
			default: pdiv_max = 3'h7;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			hdiv_cnt_q <= 2'h0;
			pdiv_cnt_q <= 3'h0;
		end else begin
			hdiv_cnt_q <= bus_tick ? 2'h0 : hdiv_cnt_q + 2'h1;
			if (bus_tick) begin
				pdiv_cnt_q <= (pdiv_cnt_q >= pdiv_max) ? 3'h0 : pdiv_cnt_q + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			pgm_cnt_q <= 8'h00;
			pgm_clock_en <= 1'b0;
		end else if (running) begin
			pgm_cnt_q <= (pgm_cnt_q >= pgmdiv_q) ? 8'h00 : pgm_cnt_q + 8'h01;
			pgm_clock_en <= pgm_cnt_q >= pgmdiv_q;
		end else begin
			pgm_clock_en <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			core_clock_en <= 1'b0;
			bus_clock_en <= 1'b0;
			periph_clock_en <= 1'b0;
			xtal_clock_en <= 1'b0;
			usb_pll_en <= 1'b0;
			main_osc_en <= 1'b0;
			display_en <= 1'b0;
		end else begin
			core_clock_en <= state_q == csr_pkg::ST_RUN;
			bus_clock_en <= running && bus_tick && !bus_gate_q;
			periph_clock_en <= running && bus_tick && pdiv_cnt_q == pdiv_max;
			xtal_clock_en <= running;
			usb_pll_en <= running;
			main_osc_en <= running;
			display_en <= running && clkset_q[5];
		end
	end

	// ------------------------------------------------------------
	// Slow oscillator and seconds counter
	// ------------------------------------------------------------
	// Slow domain state is not cleared by soft resets so time keeps running.
	logic [14:0] ripple_q;
	logic [31:0] rtc_q;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ripple_q <= 15'h0000;
			rtc_q <= 32'h0000_0000;
			rtc_second_tick <= 1'b0;
		end else begin
			rtc_second_tick <= 1'b0;
			if (slow_osc_tick) begin
				ripple_q <= ripple_q + 15'h0001;
				if (ripple_q == csr_pkg::SLOW_PER_SEC) begin
					rtc_second_tick <= 1'b1;
					rtc_q <= rtc_q + 32'h0000_0001;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Boot straps
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			strap_pending_q <= 1'b1;
			boot_sync_media <= 1'b0;
			boot_width <= csr_pkg::WIDTH_8;
			boot_flash <= 1'b0;
			boot_mode_reg_init <= 1'b0;
			boot_bank_sync4 <= 1'b0;
		end else if (!power_on_reset_n) begin
			strap_pending_q <= 1'b1;
		end else if (strap_pending_q && por_q) begin
			strap_pending_q <= 1'b0;
			boot_sync_media <= boot_media_select;
			boot_bank_sync4 <= boot_media_select;
			boot_mode_reg_init <= boot_media_select;
			if (boot_media_select) begin
				boot_width <= boot_width_bit1 ? csr_pkg::WIDTH_32 : csr_pkg::WIDTH_16;
				boot_flash <= !boot_width_bit0;
			end else begin
				boot_flash <= 1'b0;
				boot_width <= boot_width_bit1 ? csr_pkg::WIDTH_32
					: (boot_width_bit0 ? csr_pkg::WIDTH_16 : csr_pkg::WIDTH_8);
			end
		end
	end

	// ------------------------------------------------------------
	// Avalon-MM slave, one wait cycle per access
	// ------------------------------------------------------------
	// Read data is fetched on the request edge and stands while waitrequest is low.
	// Writes are committed at the answer edge, where the master samples waitrequest
	// low, so a write never lands before the master sees its access complete.
	// Every access therefore costs two cycles; back-to-back accesses are allowed.
	logic ack_q;
	logic req;
	assign req = (avs_read || avs_write) && !ack_q;
	assign halt_req = pwrctl_bit(avs_write, ack_q, avs_address, avs_writedata[0]);
	assign run_req = pwrctl_bit(avs_write, ack_q, avs_address, avs_writedata[1]);

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ack_q <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			ack_q <= req;
			avs_waitrequest <= !req;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			clkset_q <= csr_pkg::CLKSET_RESET;
			pgmdiv_q <= csr_pkg::PGMDIV_RESET;
			bus_gate_q <= 1'b0;
		end else if (avs_write && ack_q) begin
			case (avs_address)
				csr_pkg::ADDR_CLKSET: begin
					clkset_q <= avs_writedata[7:0];
					bus_gate_q <= avs_writedata[4];
				end
				csr_pkg::ADDR_PGMDIV: pgmdiv_q <= avs_writedata[7:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			avs_readdata <= csr_pkg::UNMAPPED_DATA;
		end else if (avs_read && !ack_q) begin
			case (avs_address)
				csr_pkg::ADDR_CLKSET: avs_readdata <= {24'h000000, clkset_q};
				csr_pkg::ADDR_STATUS: avs_readdata <= {24'h000000, srcs_q, kind_q,
					state_q};
				csr_pkg::ADDR_RTC: avs_readdata <= rtc_q;
				csr_pkg::ADDR_BOOT: avs_readdata <= {26'h0000000, boot_bank_sync4,
					boot_mode_reg_init, boot_flash, boot_width, boot_sync_media};
				csr_pkg::ADDR_PGMDIV: avs_readdata <= {24'h000000, pgmdiv_q};
				default: avs_readdata <= csr_pkg::UNMAPPED_DATA;
			endcase
		end
	end
endmodule : clock_state_reset_control

/* File: design/csr_pkg.sv */
// Constants for the clock and state controller.
// Assumes one 125 MHz core clock and a synchronous active-low reset.
// What this block does
// - Slow oscillator tick always counted, drives only the seconds counter.
// - Ripple divider makes 1 Hz, advances seconds counter.
// - Crystal feeds both PLLs, peripherals, programmable divider.
// - Bus clock is core clock divided 1-4.
// - Bus clock gated by power-saving logic.
// - Peripheral clock is bus clock divided 2/4/8.
// - USB PLL only feeds fixed USB clock.
// - Run enables every clock, core included; bus clock stays off while clkset_q[4] is set, display needs clkset_q[5].
// - Halt stops only the core clock.
// - Standby disables display, stops main oscillator.
// - Any reset input asserts internal system reset.
// - Soft resets spare SDRAM config and RTC.
// - Soft resets request SDRAM self-refresh first.
// - Leaving reset enters Standby.
// - Status register records last reset kind, source.
// - Boot media pin latched at power-on reset.
// - Width pins decoded per boot media.
// - Boot bank mapped to address zero.
package csr_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CLKSET = 4'h0;
	localparam logic [3:0] ADDR_PWRCTL = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_RTC = 4'h3;
	localparam logic [3:0] ADDR_BOOT = 4'h4;
	localparam logic [3:0] ADDR_PGMDIV = 4'h5;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	localparam logic [7:0] CLKSET_RESET = 8'h00;
	localparam logic [7:0] PGMDIV_RESET = 8'h01;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SLOW_HZ = 32768;
	localparam logic [14:0] SLOW_PER_SEC = 15'h7FFF;
	localparam logic [2:0] SREFRESH_CYCLES = 3'h4;
	localparam logic [1:0] SYNC_STAGES = 2'h2;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_SREFRESH = 3'b001,
		ST_STANDBY = 3'b010,
		ST_RUN = 3'b011,
		ST_HALT = 3'b100
	} pstate_t;
	localparam logic [1:0] KIND_POR = 2'h1;
	localparam logic [1:0] KIND_PWRFAIL = 2'h2;
	localparam logic [1:0] KIND_USER = 2'h3;
	localparam logic [1:0] WIDTH_8 = 2'h0;
	localparam logic [1:0] WIDTH_16 = 2'h1;
	localparam logic [1:0] WIDTH_32 = 2'h2;
endpackage : csr_pkg

/* File: test/board_model.sv */
// Board side: reset buttons, boot straps, slow oscillator tick, SDRAM acknowledge.
// Assumes the bench asks for resets as active-high levels ordered {user, fail, power-on}.
`timescale 1ns/10ps
module board_model (
	input wire logic core_clk,
	input wire logic [2:0] rst_cmd,
	input wire logic [2:0] strap_cmd,
	input wire logic sdram_self_refresh_req,
	output logic power_on_reset_n,
	output logic power_fail_n,
	output logic user_reset_n,
	output logic [2:0] strap_pins,
	output logic sdram_self_refresh_ack,
	output logic slow_osc_tick
);
	logic [3:0] por_age_q = 4'h0;
	initial begin
		{user_reset_n, power_fail_n, power_on_reset_n} = 3'h6;
		sdram_self_refresh_ack = 1'h0;
		slow_osc_tick = 1'h0;
	end
	// Straps are only held around power-on release; later the pins wander on purpose.
	assign strap_pins = (por_age_q == 4'hF) ? ~strap_cmd : strap_cmd;
	always @(posedge core_clk) begin
		{user_reset_n, power_fail_n, power_on_reset_n} <= ~rst_cmd;
		por_age_q <= !power_on_reset_n ? 4'h0 : (por_age_q == 4'hF) ? 4'hF : por_age_q + 4'h1;
		sdram_self_refresh_ack <= sdram_self_refresh_req && !sdram_self_refresh_ack;
		slow_osc_tick <= ~slow_osc_tick;
	end
endmodule : board_model

/* File: test/csrc_sva.sv */
// Checker for the clock and state controller, bound to its top-level ports.
// Assumes one clock domain with the synchronous active-low reset.
`timescale 1ns/10ps
module csrc_sva (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic power_on_reset_n,
	input wire logic power_fail_n,
	input wire logic user_reset_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic system_reset_n,
	input wire logic domain_reset_n,
	input wire logic sdram_self_refresh_req,
	input wire logic core_clock_en,
	input wire logic main_osc_en,
	input wire logic usb_pll_en,
	input wire logic xtal_clock_en,
	input wire logic display_en,
	input wire logic boot_sync_media,
	input wire logic [1:0] boot_width,
	input wire logic boot_mode_reg_init,
	input wire logic boot_bank_sync4
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_soft; $fell(user_reset_n) || $fell(power_fail_n); endsequence
	property p_run; core_clock_en |-> main_osc_en && usb_pll_en && xtal_clock_en; endproperty
	a_run: assert property (p_run) else $error("core clock without other clocks");
	property p_standby; !main_osc_en |-> !display_en && !core_clock_en; endproperty
	a_standby: assert property (p_standby) else $error("standby with clocks on");
	property p_por; !power_on_reset_n |-> ##[1:3] !system_reset_n; endproperty
	a_por: assert property (p_por) else $error("no system reset on power-on");
	property p_soft_rst; !user_reset_n || !power_fail_n |-> ##[1:12] !system_reset_n; endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("no system reset on soft");
	property p_domain; s_soft ##0 domain_reset_n |=> domain_reset_n [*6]; endproperty
	a_domain: assert property (p_domain) else $error("kept domain was reset");
	property p_sref; s_soft ##0 core_clock_en |-> ##[1:6] sdram_self_refresh_req; endproperty
	a_sref: assert property (p_sref) else $error("no self-refresh before soft reset");
	property p_no_sref;
		$fell(power_on_reset_n) && !sdram_self_refresh_req |=> !sdram_self_refresh_req [*4];
	endproperty
	a_no_sref: assert property (p_no_sref) else $error("self-refresh on power-on");
	property p_leave; $rose(system_reset_n) |-> !core_clock_en [*4]; endproperty
	a_leave: assert property (p_leave) else $error("reset exit not to standby");
	property p_boot;
		boot_sync_media |-> boot_mode_reg_init && boot_bank_sync4 && boot_width != csr_pkg::WIDTH_8;
	endproperty
	a_boot: assert property (p_boot) else $error("sync boot decode wrong");
	property p_strap;
		power_on_reset_n && $past(power_on_reset_n, 8) && $past(resetn, 8)
			|-> $stable(boot_width) && $stable(boot_sync_media);
	endproperty
	a_strap: assert property (p_strap) else $error("latched straps moved");
	property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer timing wrong");
endmodule : csrc_sva
bind clock_state_reset_control csrc_sva chk (.core_clk(core_clk), .resetn(resetn),
	.power_on_reset_n(power_on_reset_n), .power_fail_n(power_fail_n), .user_reset_n(user_reset_n),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.system_reset_n(system_reset_n), .domain_reset_n(domain_reset_n),
	.sdram_self_refresh_req(sdram_self_refresh_req), .core_clock_en(core_clock_en),
	.main_osc_en(main_osc_en), .usb_pll_en(usb_pll_en), .xtal_clock_en(xtal_clock_en),
	.display_en(display_en), .boot_sync_media(boot_sync_media), .boot_width(boot_width),
	.boot_mode_reg_init(boot_mode_reg_init), .boot_bank_sync4(boot_bank_sync4));

/* File: test/clock_state_reset_control_tb_top.sv */
// Bench for the clock and state controller: bus tasks, power-state and reset walks.
// Assumes the board model supplies reset pins, straps, slow tick and SDRAM acknowledge.
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module clock_state_reset_control_tb_top;
	logic core_clk = 1'h0, resetn = 1'h0, wake_event = 1'h0, wakeup_pin = 1'h0;
	logic main_pll_locked = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
	logic seen_sr = 1'h0, dom_low = 1'h0;
	logic [2:0] rst_cmd = 3'h1, strap_cmd = 3'h5, strap_pins;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rtc_a, rtc_b, rd;
	logic avs_waitrequest, system_reset_n, domain_reset_n, sdram_self_refresh_req;
	logic core_clock_en, bus_clock_en, periph_clock_en, xtal_clock_en, usb_pll_en;
	logic main_osc_en, display_en, rtc_second_tick, pgm_clock_en, boot_sync_media;
	logic boot_flash, boot_mode_reg_init, boot_bank_sync4, sdram_self_refresh_ack;
	logic slow_osc_tick, power_on_reset_n, power_fail_n, user_reset_n;
	logic [1:0] boot_width;
	int fails = 0, total_checks = 0, cycles = 0, nb, np, ng;
	always #4 core_clk = ~core_clk;
	board_model board (.core_clk(core_clk), .rst_cmd(rst_cmd), .strap_cmd(strap_cmd),
		.sdram_self_refresh_req(sdram_self_refresh_req), .power_on_reset_n(power_on_reset_n),
		.power_fail_n(power_fail_n), .user_reset_n(user_reset_n), .strap_pins(strap_pins),
		.sdram_self_refresh_ack(sdram_self_refresh_ack), .slow_osc_tick(slow_osc_tick));
	clock_state_reset_control DUT (.core_clk(core_clk), .resetn(resetn),
		.power_on_reset_n(power_on_reset_n), .power_fail_n(power_fail_n),
		.user_reset_n(user_reset_n), .slow_osc_tick(slow_osc_tick),
		.main_pll_locked(main_pll_locked), .wake_event(wake_event), .wakeup_pin(wakeup_pin),
		.sdram_self_refresh_ack(sdram_self_refresh_ack), .boot_media_select(strap_pins[2]),
		.boot_width_bit0(strap_pins[0]), .boot_width_bit1(strap_pins[1]),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .system_reset_n(system_reset_n),
		.domain_reset_n(domain_reset_n), .sdram_self_refresh_req(sdram_self_refresh_req),
		.core_clock_en(core_clock_en), .bus_clock_en(bus_clock_en),
		.periph_clock_en(periph_clock_en), .xtal_clock_en(xtal_clock_en),
		.usb_pll_en(usb_pll_en), .main_osc_en(main_osc_en), .display_en(display_en),
		.rtc_second_tick(rtc_second_tick), .pgm_clock_en(pgm_clock_en),
		.boot_sync_media(boot_sync_media), .boot_width(boot_width), .boot_flash(boot_flash),
		.boot_mode_reg_init(boot_mode_reg_init), .boot_bank_sync4(boot_bank_sync4));
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	always @(posedge core_clk) begin
		cycles++;
		if (sdram_self_refresh_req === 1'h1) seen_sr = 1'h1;
		if (domain_reset_n === 1'h0 && cycles > 100) dom_low = 1'h1;
		if (cycles == 90000) begin
			fails++;
			close_out();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
		output logic [31:0] q);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'h1, a, d, rd);
	endtask : wr
	task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string n);
		bus(1'h0, a, 32'h0, rd);
		`CHK(n, e, rd)
	endtask : rdchk
	task automatic count(input int n);
		nb = 0;
		np = 0;
		ng = 0;
		repeat (n) begin
			@(posedge core_clk);
			nb += bus_clock_en;
			np += periph_clock_en;
			ng += pgm_clock_en;
		end
	endtask : count
	task automatic pulse_reset(input logic [2:0] c);
		seen_sr = 1'h0;
		rst_cmd <= c;
		cyc(20);
		`CHK("system reset", 1'h0, system_reset_n)
		rst_cmd <= 3'h0;
		cyc(30);
	endtask : pulse_reset
	initial begin
		cyc(5);
		resetn <= 1'h1;
		cyc(2);
		rst_cmd <= 3'h0;
		cyc(30);
		`CHK("core standby", 1'h0, core_clock_en)
		`CHK("osc standby", 1'h0, main_osc_en)
		`CHK("display standby", 1'h0, display_en)
		rdchk(csr_pkg::ADDR_STATUS, 32'h2A, "status");
		rdchk(csr_pkg::ADDR_BOOT, 32'h33, "boot sync");
		rdchk(csr_pkg::ADDR_CLKSET, 32'(csr_pkg::CLKSET_RESET), "clkset");
		rdchk(csr_pkg::ADDR_PGMDIV, 32'(csr_pkg::PGMDIV_RESET), "divider");
		rdchk(4'h6, csr_pkg::UNMAPPED_DATA, "unmapped");
		wr(csr_pkg::ADDR_STATUS, 32'hFF);
		rdchk(csr_pkg::ADDR_STATUS, 32'h2A, "status ro");
		// The two samples are 65536 edges apart: exactly 32768 slow ticks, one second.
		bus(1'h0, csr_pkg::ADDR_RTC, 32'h0, rtc_a);
		cyc(65533);
		bus(1'h0, csr_pkg::ADDR_RTC, 32'h0, rtc_b);
		`CHK("rtc step", 32'h1, rtc_b - rtc_a)
		wakeup_pin <= 1'h1;
		main_pll_locked <= 1'h1;
		cyc(10);
		wakeup_pin <= 1'h0;
		`CHK("core run", 1'h1, core_clock_en)
		rdchk(csr_pkg::ADDR_STATUS, 32'h2B, "status run");
		for (int b = 0; b < 4; b++) begin
			for (int p = 0; p < 3; p++) begin
				wr(csr_pkg::ADDR_CLKSET, 32'(p * 4 + b));
				cyc(20);
				count(192);
				`CHK("bus div", 192 / (b + 1), nb)
				`CHK("periph div", 192 / ((b + 1) * (2 << p)), np)
			end
		end
		wr(csr_pkg::ADDR_CLKSET, 32'h20);
		cyc(4);
		`CHK("display run", 1'h1, display_en)
		wr(csr_pkg::ADDR_PGMDIV, 32'h4);
		cyc(10);
		count(200);
		`CHK("prog div", 40, ng)
		wr(csr_pkg::ADDR_PWRCTL, 32'h1);
		cyc(4);
		`CHK("core halt", 1'h0, core_clock_en)
		`CHK("usb halt", 1'h1, usb_pll_en)
		rdchk(csr_pkg::ADDR_STATUS, 32'h2C, "status halt");
		wake_event <= 1'h1;
		cyc(4);
		wake_event <= 1'h0;
		`CHK("core wake", 1'h1, core_clock_en)
		pulse_reset(3'h4);
		`CHK("refresh user", 1'h1, seen_sr)
		`CHK("domain kept", 1'h0, dom_low)
		rdchk(csr_pkg::ADDR_STATUS, 32'h9A, "status user");
		rdchk(csr_pkg::ADDR_BOOT, 32'h33, "boot kept");
		bus(1'h0, csr_pkg::ADDR_RTC, 32'h0, rtc_a);
		`CHK("rtc kept", 1'h1, rtc_a - rtc_b <= 32'h1)
		pulse_reset(3'h2);
		`CHK("refresh fail", 1'h1, seen_sr)
		rdchk(csr_pkg::ADDR_STATUS, 32'h52, "status fail");
		strap_cmd <= 3'h2;
		pulse_reset(3'h1);
		`CHK("refresh por", 1'h0, seen_sr)
		rdchk(csr_pkg::ADDR_STATUS, 32'h2A, "status por");
		rdchk(csr_pkg::ADDR_BOOT, 32'h04, "boot async");
		close_out();
	end
endmodule : clock_state_reset_control_tb_top
